// ### design/gpx_defs.svh
// gpx_defs.svh: register codes, field kinds, reset values and bus constants
// assumes: included by bare name from every design file that needs it
`ifndef GPX_DEFS_SVH
`define GPX_DEFS_SVH

// ----------------------------------------------------------------
// register codes held in the register pointer
// ----------------------------------------------------------------
`define GPX_REG_IN0 3'h0
`define GPX_REG_IN1 3'h1
`define GPX_REG_OUT0 3'h2
`define GPX_REG_OUT1 3'h3
`define GPX_REG_INV0 3'h4
`define GPX_REG_INV1 3'h5
`define GPX_REG_DIR0 3'h6
`define GPX_REG_DIR1 3'h7

// ----------------------------------------------------------------
// register kind, pointer bits 2:1; pointer bit 0 picks the port
// ----------------------------------------------------------------
`define GPX_KIND_IN 2'h0
`define GPX_KIND_OUT 2'h1
`define GPX_KIND_INV 2'h2
`define GPX_KIND_DIR 2'h3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define GPX_OUT_RST 8'hff
`define GPX_INV_RST 8'h00
`define GPX_DIR_RST 8'hff
`define GPX_PTR_RST 3'h0

// ----------------------------------------------------------------
// serial bus
// ----------------------------------------------------------------
`define GPX_ADDR_HI 4'h4
`define GPX_BYTE_BITS 4'h8
`define GPX_RW_READ 1'b1

`endif

// ### design/gpx_pkg.sv
// gpx_pkg: state types of the serial expander
// assumes: nothing beyond the defs header
package gpx_pkg;

    // ----------------------------------------------------------------
    // serial target states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        st_idle,
        st_addr,
        st_addr_ack,
        st_cmd,
        st_cmd_ack,
        st_wdata,
        st_wdata_ack,
        st_rdata,
        st_rdata_ack
    } gpx_state_e;

    // ----------------------------------------------------------------
    // state of the top module
    // ----------------------------------------------------------------
    typedef struct packed {
        gpx_state_e state;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic [2:0] pointer;
        logic rw;
        logic sda_oe;
        logic sda_val;
        logic scl_d;
        logic sda_d;
        logic alert_n;
        logic alert_oe;
    } gpx_link_s;

    // ----------------------------------------------------------------
    // state of one 8-line port
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] invert;
        logic [7:0] dir;
        logic [7:0] captured;
        logic [7:0] pin_out;
        logic [7:0] pin_oe;
        logic primed;
    } gpx_port_s;

endpackage : gpx_pkg

// ### design/gpx_sync.sv
// gpx_sync: three-stage input synchroniser with agreement filter
// assumes: inputs are asynchronous to ref_clk; output changes once stages 2 and 3 agree
`timescale 1ns/1ps

module gpx_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // data
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } gpx_sync_s;

    gpx_sync_s r;
    gpx_sync_s next_r;

    // ----------------------------------------------------------------
    // stage chain; stage 1 feeds stage 2 only
    // ----------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.s1 = d_in;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        next_r.q = (r.s2 & ~(r.s2 ^ r.s3)) | (r.q & (r.s2 ^ r.s3));
    end

    // stages keep sampling in reset so the levels are valid at release
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            r.s1 <= d_in;
            r.s2 <= r.s1;
            r.s3 <= r.s2;
            r.q <= (r.s2 & ~(r.s2 ^ r.s3)) | (RST_VAL & (r.s2 ^ r.s3));
        end else begin
            r <= next_r;
        end
    end

    assign q_out = r.q;

endmodule : gpx_sync

// ### design/gpx_port.sv
// gpx_port: one 8-line port with output latch, inversion, direction and change detect
// assumes: pin levels already synchronised to ref_clk; writes are one-cycle strobes
`timescale 1ns/1ps
`include "gpx_defs.svh"

module gpx_port (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // register access
    input wire logic wr_en,
    input wire logic [1:0] wr_kind,
    input wire logic [7:0] wr_data,
    input wire logic [1:0] rd_kind,
    output logic [7:0] rd_data,
    input wire logic read_ack,
    // pins
    input wire logic [7:0] pin_level,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    // change detect
    output logic changed
);

    gpx_pkg::gpx_port_s r;
    gpx_pkg::gpx_port_s next_r;

    // ----------------------------------------------------------------
    // register writes and pin drive
    // ----------------------------------------------------------------
    always_comb begin
        next_r = r;
        if (!r.primed || read_ack) begin
            next_r.captured = pin_level;
        end
        next_r.primed = 1'b1;
        if (wr_en) begin
            case (wr_kind)
                `GPX_KIND_OUT: next_r.latch = wr_data;
                `GPX_KIND_INV: next_r.invert = wr_data;
                `GPX_KIND_DIR: next_r.dir = wr_data;
                default: next_r = next_r;
            endcase
        end
        next_r.pin_out = next_r.latch;
        next_r.pin_oe = ~next_r.dir;
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            r.latch <= `GPX_OUT_RST;
            r.invert <= `GPX_INV_RST;
            r.dir <= `GPX_DIR_RST;
            r.captured <= 8'h00;
            r.pin_out <= `GPX_OUT_RST;
            r.pin_oe <= 8'h00;
            r.primed <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------------------------------
    // read mux and change compare
    // ----------------------------------------------------------------
    always_comb begin
        case (rd_kind)
            `GPX_KIND_IN: rd_data = pin_level ^ r.invert;
            `GPX_KIND_OUT: rd_data = r.latch;
            `GPX_KIND_INV: rd_data = r.invert;
            default: rd_data = r.dir;
        endcase
    end

    assign changed = r.primed & (|((pin_level ^ r.captured) & r.dir));
    assign pin_out = r.pin_out;
    assign pin_oe = r.pin_oe;

endmodule : gpx_port

// ### design/gpx_expander.sv
// gpx_expander: two-wire serial target with sixteen general-purpose lines
// assumes: scl, sda, straps and port lines are asynchronous pins; the board
// resolves open-drain sda and the alert from the enables
// reset: hold nrst low for at least four clocks so the pin stages fill
`timescale 1ns/1ps
`include "gpx_defs.svh"

module gpx_expander #(
    parameter logic [3:0] ADDR_HI = `GPX_ADDR_HI
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // serial bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // address straps
    input wire logic addr_strap_0,
    input wire logic addr_strap_1,
    input wire logic addr_strap_2,
    // port 0 lines
    input wire logic [7:0] port_zero_lines_in,
    output logic [7:0] port_zero_lines_out,
    output logic [7:0] port_zero_lines_oe,
    // port 1 lines
    input wire logic [7:0] port_one_lines_in,
    output logic [7:0] port_one_lines_out,
    output logic [7:0] port_one_lines_oe,
    // change alert, open drain, active low
    output logic change_alert_n_out,
    output logic change_alert_n_oe
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    localparam int SYNC_W = 21;
    localparam logic [SYNC_W-1:0] SYNC_RST = {3'h0, 2'h3, 16'h0000};

    logic [SYNC_W-1:0] sync_q;
    logic [7:0] lvl0;
    logic [7:0] lvl1;
    logic scl;
    logic sda;
    logic [2:0] strap;

    gpx_sync #(
        .W(SYNC_W),
        .RST_VAL(SYNC_RST)
    ) u_sync (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .d_in({addr_strap_2, addr_strap_1, addr_strap_0, sda_in, scl_in,
               port_one_lines_in, port_zero_lines_in}),
        .q_out(sync_q)
    );

    assign lvl0 = sync_q[7:0];
    assign lvl1 = sync_q[15:8];
    assign scl = sync_q[16];
    assign sda = sync_q[17];
    assign strap = sync_q[20:18];

    // ----------------------------------------------------------------
    // ports
    // ----------------------------------------------------------------
    gpx_pkg::gpx_link_s r;
    gpx_pkg::gpx_link_s next_r;

    logic wr_en0;
    logic wr_en1;
    logic ack0;
    logic ack1;
    logic [7:0] rd0;
    logic [7:0] rd1;
    logic chg0;
    logic chg1;

    gpx_port u_port0 (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .wr_en(wr_en0),
        .wr_kind(r.pointer[2:1]),
        .wr_data(r.shift),
        .rd_kind(r.pointer[2:1]),
        .rd_data(rd0),
        .read_ack(ack0),
        .pin_level(lvl0),
        .pin_out(port_zero_lines_out),
        .pin_oe(port_zero_lines_oe),
        .changed(chg0)
    );

    gpx_port u_port1 (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .wr_en(wr_en1),
        .wr_kind(r.pointer[2:1]),
        .wr_data(r.shift),
        .rd_kind(r.pointer[2:1]),
        .rd_data(rd1),
        .read_ack(ack1),
        .pin_level(lvl1),
        .pin_out(port_one_lines_out),
        .pin_oe(port_one_lines_oe),
        .changed(chg1)
    );

    // ----------------------------------------------------------------
    // serial target
    // ----------------------------------------------------------------
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic is_input;
    logic byte_done;
    logic [7:0] rd_byte;
    logic wr_strobe;
    logic ack_strobe;
    logic alert_any;

    always_comb begin
        scl_rise = scl & ~r.scl_d;
        scl_fall = ~scl & r.scl_d;
        start_seen = r.scl_d & scl & r.sda_d & ~sda;
        stop_seen = r.scl_d & scl & ~r.sda_d & sda;
        is_input = (r.pointer[2:1] == `GPX_KIND_IN);
        byte_done = (r.bit_cnt == `GPX_BYTE_BITS);
        if (!r.pointer[0]) begin
            rd_byte = rd0;
        end else begin
            rd_byte = rd1;
        end
    end

    // ----------------------------------------------------------------
    // register decode; pointer bit 0 picks the port
    // ----------------------------------------------------------------
    always_comb begin
        wr_en0 = 1'b0;
        wr_en1 = 1'b0;
        ack0 = 1'b0;
        ack1 = 1'b0;
        if (is_input) begin
            ack0 = ack_strobe && !r.pointer[0];
            ack1 = ack_strobe && r.pointer[0];
        end else if (!r.pointer[0]) begin
            wr_en0 = wr_strobe;
        end else begin
            wr_en1 = wr_strobe;
        end
    end

    // ----------------------------------------------------------------
    // change alert
    // ----------------------------------------------------------------
    assign alert_any = chg0 | chg1;

    always_comb begin
        next_r = r;
        wr_strobe = 1'b0;
        ack_strobe = 1'b0;
        next_r.scl_d = scl;
        next_r.sda_d = sda;
        next_r.sda_val = 1'b0;
        if (start_seen) begin
            next_r.state = gpx_pkg::st_addr;
            next_r.bit_cnt = 4'h0;
            next_r.sda_oe = 1'b0;
        end else if (stop_seen) begin
            next_r.state = gpx_pkg::st_idle;
            next_r.sda_oe = 1'b0;
        end else begin
            case (r.state)
                gpx_pkg::st_addr, gpx_pkg::st_cmd, gpx_pkg::st_wdata: begin
                    if (scl_rise) begin
                        next_r.shift = {r.shift[6:0], sda};
                        next_r.bit_cnt = r.bit_cnt + 4'h1;
                    end else if (scl_fall && byte_done) begin
                        next_r.sda_oe = 1'b1;
                        if (r.state == gpx_pkg::st_addr) begin
                            if (r.shift[7:1] == {ADDR_HI, strap}) begin
                                next_r.rw = r.shift[0];
                                next_r.state = gpx_pkg::st_addr_ack;
                            end else begin
                                next_r.sda_oe = 1'b0;
                                next_r.state = gpx_pkg::st_idle;
                            end
                        end else if (r.state == gpx_pkg::st_cmd) begin
                            next_r.pointer = r.shift[2:0];
                            next_r.state = gpx_pkg::st_cmd_ack;
                        end else begin
                            wr_strobe = 1'b1;
                            next_r.pointer = {r.pointer[2:1], ~r.pointer[0]};
                            next_r.state = gpx_pkg::st_wdata_ack;
                        end
                    end
                end
                gpx_pkg::st_addr_ack: begin
                    if (scl_fall) begin
                        next_r.bit_cnt = 4'h0;
                        if (r.rw == `GPX_RW_READ) begin
                            next_r.shift = rd_byte;
                            next_r.sda_oe = ~rd_byte[7];
                            next_r.state = gpx_pkg::st_rdata;
                        end else begin
                            next_r.sda_oe = 1'b0;
                            next_r.state = gpx_pkg::st_cmd;
                        end
                    end
                end
                gpx_pkg::st_cmd_ack, gpx_pkg::st_wdata_ack: begin
                    if (scl_fall) begin
                        next_r.bit_cnt = 4'h0;
                        next_r.sda_oe = 1'b0;
                        next_r.state = gpx_pkg::st_wdata;
                    end
                end
                gpx_pkg::st_rdata: begin
                    if (scl_rise) begin
                        next_r.bit_cnt = r.bit_cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (byte_done) begin
                            next_r.sda_oe = 1'b0;
                            next_r.state = gpx_pkg::st_rdata_ack;
                        end else begin
                            next_r.shift = {r.shift[6:0], 1'b0};
                            next_r.sda_oe = ~r.shift[6];
                        end
                    end
                end
                gpx_pkg::st_rdata_ack: begin
                    if (scl_rise) begin
                        ack_strobe = 1'b1;
                        next_r.pointer = {r.pointer[2:1], ~r.pointer[0]};
                        if (sda) begin
                            next_r.state = gpx_pkg::st_idle;
                        end
                    end else if (scl_fall) begin
                        next_r.bit_cnt = 4'h0;
                        next_r.shift = rd_byte;
                        next_r.sda_oe = ~rd_byte[7];
                        next_r.state = gpx_pkg::st_rdata;
                    end
                end
                default: begin
                    next_r.sda_oe = 1'b0;
                end
            endcase
        end
        next_r.alert_oe = alert_any;
        next_r.alert_n = ~alert_any;
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            r.state <= gpx_pkg::st_idle;
            r.bit_cnt <= 4'h0;
            r.shift <= 8'h00;
            r.pointer <= `GPX_PTR_RST;
            r.rw <= 1'b0;
            r.sda_oe <= 1'b0;
            r.sda_val <= 1'b0;
            r.scl_d <= 1'b1;
            r.sda_d <= 1'b1;
            r.alert_n <= 1'b1;
            r.alert_oe <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign sda_out = r.sda_val;
    assign sda_oe = r.sda_oe;
    assign change_alert_n_out = r.alert_n;
    assign change_alert_n_oe = r.alert_oe;

endmodule : gpx_expander

// ### testbench/gpx_host_model.sv
// gpx_host_model: two-wire bus controller model
// assumes: the bench resolves sda with a pull-up; speed is set by half
`timescale 1ns/1ps

module gpx_host_model (
    // clock
    input wire logic ref_clk,
    // bus
    input wire logic sda_wire,
    output logic scl,
    output logic sda_low
);
    int half = 8;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic tick();
        repeat (half) @(posedge ref_clk);
    endtask : tick

    // start from idle or as a repeated start
    task automatic start_c();
        sda_low <= 1'b0;
        tick();
        scl <= 1'b1;
        tick();
        sda_low <= 1'b1;
        tick();
        scl <= 1'b0;
        tick();
    endtask : start_c

    task automatic stop_c();
        sda_low <= 1'b1;
        tick();
        scl <= 1'b1;
        tick();
        sda_low <= 1'b0;
        tick();
    endtask : stop_c

    // eight bits and the acknowledge, msb first, sda moved only while scl is low
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            repeat (3) @(posedge ref_clk);
            sda_low <= ~d[i];
            repeat (half - 3) @(posedge ref_clk);
            scl <= 1'b1;
            tick();
            q[i] = sda_wire;
            scl <= 1'b0;
        end
    endtask : xfer
endmodule : gpx_host_model

// ### testbench/gpx_expander_asserts.sv
// gpx_expander_asserts: port checks of the expander
// assumes: bound to gpx_expander; scl_in is the bus clock pin
`timescale 1ns/1ps

module gpx_expander_asserts (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // serial bus
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // port lines
    input wire logic [7:0] port_zero_lines_out,
    input wire logic [7:0] port_zero_lines_oe,
    input wire logic [7:0] port_one_lines_out,
    input wire logic [7:0] port_one_lines_oe,
    // alert
    input wire logic change_alert_n_out,
    input wire logic change_alert_n_oe
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    AST_RST_LATCH:
    assert property ($rose(nrst) |-> port_zero_lines_out == 8'hff && port_one_lines_out == 8'hff)
        else $error("latch not at reset value");
    AST_RST_FLOAT:
    assert property ($rose(nrst) |-> (port_zero_lines_oe | port_one_lines_oe) == 8'h00
        && !sda_oe && !change_alert_n_oe) else $error("driving after reset");
    AST_LATCH_LOW:
    assert property ($changed(port_zero_lines_out) || $changed(port_one_lines_out) |-> !scl_in)
        else $error("latch moved while scl high");
    AST_DIR_LOW:
    assert property ($changed(port_zero_lines_oe) || $changed(port_one_lines_oe) |-> !scl_in)
        else $error("direction moved while scl high");
    AST_DIR_HOLD:
    assert property (scl_in [*3] |-> $stable(port_one_lines_oe))
        else $error("direction unstable");
    AST_SDA_LOW:
    assert property (sda_oe |-> !sda_out) else $error("sda driven high");
    AST_SDA_EDGE:
    assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in, 2))
        else $error("sda moved near scl high");
    AST_ALERT_LEVEL:
    assert property (change_alert_n_oe != change_alert_n_out) else $error("alert level");
    AST_ALERT_INPUT:
    assert property ($rose(change_alert_n_oe) |->
        (port_zero_lines_oe & port_one_lines_oe) != 8'hff) else $error("alert from outputs");
endmodule : gpx_expander_asserts

bind gpx_expander gpx_expander_asserts i_chk (
    .ref_clk, .nrst, .scl_in, .sda_out, .sda_oe,
    .port_zero_lines_out, .port_zero_lines_oe, .port_one_lines_out, .port_one_lines_oe,
    .change_alert_n_out, .change_alert_n_oe
);

// ### testbench/tb_gpx_expander.sv
// tb_gpx_expander: self-checking bench with a register model
// assumes: host model drives scl and sda; lines resolved here
`timescale 1ns/1ps

module tb_gpx_expander;
    logic ref_clk, nrst, scl, sda_low, sda_wire, sda_out, sda_oe, al_out, al_oe;
    logic [2:0] strap;
    logic [7:0] ext0, ext1, out0, out1, oe0, oe1, w0, w1;
    logic [15:0] rnd = 16'h20d8;
    int mdl[8];
    int n_mismatch = 0;
    int total_checks = 0;
    int cyc = 0;

    assign sda_wire = !(sda_low || (sda_oe && !sda_out));
    assign w0 = (oe0 & out0) | (~oe0 & ext0);
    assign w1 = (oe1 & out1) | (~oe1 & ext1);

    gpx_host_model i_host (.ref_clk, .sda_wire, .scl, .sda_low);

    gpx_expander #(.ADDR_HI(4'h9)) i_dut (
        .ref_clk, .nrst, .scl_in(scl), .sda_in(sda_wire), .sda_out, .sda_oe,
        .addr_strap_0(strap[0]), .addr_strap_1(strap[1]), .addr_strap_2(strap[2]),
        .port_zero_lines_in(w0), .port_zero_lines_out(out0), .port_zero_lines_oe(oe0),
        .port_one_lines_in(w1), .port_one_lines_out(out1), .port_one_lines_oe(oe1),
        .change_alert_n_out(al_out), .change_alert_n_oe(al_oe)
    );

    // ----------------------------------------
    // checking and model
    // ----------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic roll(output logic [7:0] v);
        rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
        v = rnd[7:0];
    endtask : roll

    function automatic logic [7:0] want(input logic [2:0] p);
        logic [7:0] d;
        d = 8'(mdl[{2'h3, p[0]}]);
        if (p > 3'h1) return 8'(mdl[p]);
        return ((~d & 8'(mdl[{2'h1, p[0]}])) | (d & (p[0] ? ext1 : ext0)))
            ^ 8'(mdl[{2'h2, p[0]}]);
    endfunction : want

    // ----------------------------------------
    // bus transfers
    // ----------------------------------------
    task automatic head(input logic [7:0] cmd);
        logic [8:0] q;
        i_host.start_c();
        i_host.xfer({4'h9, strap, 1'b0, 1'b1}, q);
        check({7'h0, q[0]}, 8'h00);
        i_host.xfer({cmd, 1'b1}, q);
        check({7'h0, q[0]}, 8'h00);
    endtask : head

    task automatic wr(input logic [7:0] cmd, input logic [7:0] d0, input logic [7:0] d1);
        logic [8:0] q;
        head(cmd);
        i_host.xfer({d0, 1'b1}, q);
        i_host.xfer({d1, 1'b1}, q);
        check({7'h0, q[0]}, 8'h00);
        i_host.stop_c();
        if (cmd[2:1] != 2'h0) begin
            mdl[cmd[2:0]] = d0;
            mdl[cmd[2:0] ^ 3'h1] = d1;
        end
    endtask : wr

    task automatic rd(input logic [7:0] cmd);
        logic [8:0] q;
        head(cmd);
        i_host.start_c();
        i_host.xfer({4'h9, strap, 1'b1, 1'b1}, q);
        check({7'h0, q[0]}, 8'h00);
        i_host.xfer(9'h1fe, q);
        check(q[8:1], want(cmd[2:0]));
        i_host.xfer(9'h1ff, q);
        check(q[8:1], want(cmd[2:0] ^ 3'h1));
        i_host.stop_c();
    endtask : rd

    task automatic poke(input logic [7:0] m0, input logic [7:0] m1, input logic [7:0] exp);
        @(posedge ref_clk);
        ext0 <= ext0 ^ m0;
        ext1 <= ext1 ^ m1;
        repeat (20) @(posedge ref_clk);
        @(negedge ref_clk);
        check({7'h0, al_oe}, exp);
        check({7'h0, al_out}, {7'h0, ~exp[0]});
    endtask : poke

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run

    // ----------------------------------------
    // clock, timeout and sequence
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_mismatch++;
            complete_run();
        end
    end

    initial begin
        logic [7:0] a, b;
        logic [8:0] q;
        nrst = 1'b0;
        strap = 3'h5;
        roll(a);
        roll(b);
        ext0 = a;
        ext1 = b;
        mdl = '{0, 0, 255, 255, 0, 0, 255, 255};
        repeat (5) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (12) @(posedge ref_clk);
        check(oe0 | oe1, 8'h00);
        check({7'h0, al_oe}, 8'h00);
        for (int p = 0; p < 8; p += 2) rd(8'(p));
        for (int p = 2; p < 8; p += 2) begin
            roll(a);
            roll(b);
            wr({a[4:0], 3'(p)}, b, a);
        end
        for (int p = 1; p < 8; p += 2) rd(8'(p));
        check(oe0, ~8'(mdl[6]));
        check(oe1, ~8'(mdl[7]));
        check(out0, 8'(mdl[2]));
        check(out1, 8'(mdl[3]));
        wr(8'h00, ~8'(mdl[2]), ~8'(mdl[3]));
        rd(8'h02);
        wr(8'h06, 8'hff, 8'hff);
        rd(8'h00);
        poke(8'h00, 8'h00, 8'h00);
        poke(8'h10, 8'h00, 8'h01);
        poke(8'h10, 8'h00, 8'h00);
        poke(8'h00, 8'h80, 8'h01);
        rd(8'h01);
        poke(8'h00, 8'h00, 8'h00);
        rd(8'h00);
        for (int s = 0; s < 8; s++) begin
            strap <= 3'(s);
            repeat (8) @(posedge ref_clk);
            i_host.start_c();
            i_host.xfer({4'h9, 3'(s), 1'b0, 1'b1}, q);
            check({7'h0, q[0]}, 8'h00);
            i_host.start_c();
            i_host.xfer({4'h9, 3'(s) ^ 3'h2, 1'b1, 1'b1}, q);
            check({7'h0, q[0]}, 8'h01);
            i_host.stop_c();
        end
        complete_run();
    end
endmodule : tb_gpx_expander
